/* testbench/capacitive_touch_scan_control_tb.sv */
// self-checking bench of the touch scan sequencer over its register bus
// assumes the pad model on the oscillator side and a 25 MHz core clock
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module capacitive_touch_scan_control_tb;
    import tkscn_pkg::*;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdat, rd, keep;
    logic awr, wr_rdy, bv, arr, rv, irq, ok;
    logic [1:0] brs, rrs, rs;
    logic [NKEY-1:0] key_osc;
    logic [NMOD-1:0] ref_osc;
    tkscn_mod_type [NMOD-1:0] mods;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    tkscn_ctrl u_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy), .s_axi_wdata_i(wd),
        .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
        .s_axi_bresp_o(brs), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
        .s_axi_rdata_o(rdat), .s_axi_rresp_o(rrs), .key_osc_i(key_osc),
        .ref_osc_i(ref_osc), .mod_o(mods), .touch_irq_o(irq));
    tkscn_pads_model u_pads (.core_clk_i(core_clk_i), .mod_i(mods),
        .key_osc_o(key_osc), .ref_osc_o(ref_osc));

    // 40 ns clock
    always #20 core_clk_i = ~core_clk_i;

    // hang guard: the first full slot count alone takes some 33k cycles
    always @(posedge core_clk_i)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    function automatic logic [7:0] madr(int m, logic [1:0] w);
        return MOD_OFS + 8'(MOD_STRIDE * m) + {4'h0, w, 2'h0};
    endfunction

    // write: both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_i);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do
        begin
            @(posedge core_clk_i);
            n++;
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_rdy) wv <= 1'b0;
        end
        while (!(bv && bry) && n < 50);
        rs = (n < 50) ? brs : 2'h1; // a lost answer never matches
        bry <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge core_clk_i);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do
        begin
            @(posedge core_clk_i);
            n++;
            if (arv && arr) arv <= 1'b0;
        end
        while (!(rv && rry) && n < 50);
        rd = rdat;
        rs = (n < 50) ? rrs : 2'h1;
        rry <= 1'b0;
    endtask

    task automatic wait_irq();
        ok = 1'b0;
        for (int n = 0; n < 40000 && !ok; n++)
        begin
            @(posedge core_clk_i);
            ok = irq;
        end
    endtask

    task automatic t_reset();
        for (int m = 0; m < NMOD; m++)
        begin
            rdr(madr(m, MW_SKS));
            `CHK("slot select reset", 32'h000000E4, rd)
        end
        rdr(CTRL_OFS);
        `CHK("control reset", 32'h0, rd)
        rdr(8'h60);
        `CHK("unmapped resp", RESP_SLVERR, rs)
        `CHK("unmapped data", 32'h0, rd)
        $display("test reset done");
    endtask

    task automatic t_manual();
        wr(CTRL_OFS, 32'h0000FE02);
        wr(madr(0, MW_OSC), 32'h000000B4);
        wr(madr(0, MW_SKS), 32'h000000E6);
        `CHK("write resp", RESP_OKAY, rs)
        `CHK("manual key mux", 2'h2, mods[0].key_sel)
        `CHK("pin enables", 4'h4, mods[0].key_pin_en)
        wr(CTRL_OFS, 32'h0000FE03);
        rdr(CTRL_OFS);
        `CHK("busy up", 1'b1, rd[CTL_BUSY])
        wait_irq();
        `CHK("manual irq", 1'b1, ok)
        rdr(CTRL_OFS);
        `CHK("busy down", 2'h2, rd[CTL_OVF:CTL_BUSY])
        `CHK("key osc off", 1'b0, mods[0].key_osc_en)
        `CHK("ref osc off", 1'b0, mods[0].ref_osc_en)
        rdr(madr(0, MW_CNT));
        `CHK("sense counted", 1'b1, rd[15:0] != 16'h0)
        keep = rd;
        repeat (20) @(posedge core_clk_i);
        rdr(madr(0, MW_CNT));
        `CHK("count halted", keep, rd)
        wr(CTRL_OFS, 32'h0000FE02);
        rdr(madr(0, MW_CNT));
        `CHK("count cleared", 32'h0, rd)
        $display("test manual done");
    endtask

    task automatic t_auto();
        for (int i = 0; i < 8; i++)
            wr(CAP_MEM_OFS + 8'(4 * i), 32'h100 + 32'(3 * i));
        wr(madr(0, MW_SKS), 32'h0000001B);
        wr(madr(0, MW_OSC), 32'h0000008F);
        wr(madr(1, MW_SKS), 32'h00000055);
        wr(madr(1, MW_OSC), 32'h00000082);
        wr(CTRL_OFS, 32'h0000FE01);
        rdr(CTRL_OFS);
        `CHK("auto busy", 1'b1, rd[CTL_BUSY])
        `CHK("auto key osc on", 1'b1, mods[0].key_osc_en)
        `CHK("slot0 cap load", 10'h109, mods[0].ref_cap)
        wait_irq();
        `CHK("auto irq", 1'b1, ok)
        rdr(CTRL_OFS);
        `CHK("auto done flags", 2'h2, rd[CTL_OVF:CTL_BUSY])
        `CHK("auto osc off", 1'b0, mods[0].key_osc_en)
        `CHK("slot0 cap reload", 10'h109, mods[0].ref_cap)
        `CHK("module1 cap", 10'h10F, mods[1].ref_cap)
        for (int k = 0; k < KPM; k++)
        begin
            rdr(CNT_MEM_OFS + 8'(4 * k));
            `CHK("slot count stored", 1'b1, rd[15:0] != 16'h0)
        end
        rdr(CNT_MEM_OFS);
        keep = rd;
        rdr(madr(0, MW_CNT));
        `CHK("last count kept", keep[15:0], rd[15:0])
        rdr(CNT_MEM_OFS + 8'h14);
        `CHK("module1 key b", 1'b1, rd[15:0] != 16'h0)
        rdr(CNT_MEM_OFS + 8'h10);
        `CHK("module1 key a", 32'h0, rd)
        $display("test auto done");
    endtask

    // shared slot counter, manual, reference-clocked: module 1 never ticks
    task automatic t_shared();
        wr(CTRL_OFS, 32'h0000FE12);
        wr(madr(0, MW_OSC), 32'h00000038);
        wr(madr(1, MW_OSC), 32'h00000002);
        `CHK("slot3 ignored in manual", 2'h3, mods[0].key_sel)
        wr(CTRL_OFS, 32'h0000FE13);
        wait_irq();
        `CHK("shared irq", 1'b1, ok)
        rdr(CTRL_OFS);
        `CHK("shared flags", 3'h6, {rd[CTL_SHARED], rd[CTL_OVF:CTL_BUSY]})
        rdr(madr(0, MW_CNT));
        `CHK("shared key counted", 1'b1, rd[15:0] != 16'h0)
        `CHK("ref clocked slot", 1'b1, rd[31:16] != 16'h0)
        $display("test shared done");
    endtask

    // reset for five cycles, then the scenarios in turn
    initial
    begin
        repeat (5) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        t_reset();
        t_manual();
        t_auto();
        t_shared();
        wrap_up();
    end
endmodule

/* testbench/tkscn_pads_model.sv */
// touch pads with their sense and reference oscillators
// assumes the sequencer's per-module controls on mod_i, one core clock
`timescale 1ns/100ps
module tkscn_pads_model
    import tkscn_pkg::*;
(
    input wire logic core_clk_i,
    input wire tkscn_mod_type [NMOD-1:0] mod_i,
    output logic [NKEY-1:0] key_osc_o,
    output logic [NMOD-1:0] ref_osc_o
);
    logic [3:0] ph_q = 4'h0;

    // free phase counter; key pulses stay 2 cycles high and low, reference pulses 4, for the synchroniser
    always_ff @(posedge core_clk_i)
        ph_q <= ph_q + 4'h1;

    // oscillators stand still at 0 unless enabled; key oscillators also need their pin to belong to sensing
    always_comb
    begin
        for (int m = 0; m < NMOD; m++)
        begin
            for (int k = 0; k < KPM; k++)
                key_osc_o[4*m+k] = mod_i[m].key_osc_en & mod_i[m].key_pin_en[k] & ph_q[1];
            ref_osc_o[m] = mod_i[m].ref_osc_en & ph_q[2];
        end
    end
endmodule

/* verilog/tkscn_ctrl.sv */
// touch key scan sequencer: slot key selection, counters, auto scan transfers
// assumes oscillator pulses arrive asynchronously on key_osc_i and ref_osc_i
// Overview of operation
// - slot select holds four 2-bit key fields
// - slot 1-3 fields used only in auto
// - slot 0 field doubles as manual mux
// - per-key enable hands pin to sensing
// - module m owns keys 4m to 4m+3
// - shared select uses module 0 slot counter
// - one common start bit starts all modules
// - start low clears counts, keeps slot counter
// - start rising switches all counters on
// - overflow stops all counters; oscillators stop in manual or after slot 3
// - slot clock: reference oscillator or fsys/4
// - oscillators run while enable bits set
// - single interrupt: slot counter overflow in manual, after slot 3 store in auto
// - mode bit: 0 auto, 1 manual
// - auto mode drives oscillator enables itself
// - auto start: load slot0 cap, store slot3
// - each slot end: load next, store current
// - after slot 3: reload slot0, store slot3
// - four slots done: flag set, busy cleared
// - each transfer moves 2N bytes at once
// - auto count cleared after store, except slot3
`timescale 1ns/100ps
module tkscn_ctrl
    import tkscn_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [7:0] s_axi_araddr_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    input wire logic [NKEY-1:0] key_osc_i,
    input wire logic [NMOD-1:0] ref_osc_i,
    output tkscn_mod_type [NMOD-1:0] mod_o,
    output logic touch_irq_o
);
    tkscn_state_type q;
    tkscn_state_type d;
    logic [NSYN-1:0] rise_v;
    logic [NMOD-1:0][1:0] sel;
    logic slot_end;
    logic st_rise;
    logic st_fall;

    // register read view; bit 32 flags an unmapped address
    function automatic logic [32:0] reg_read(input tkscn_state_type s, input logic [7:0] a);
        logic [32:0] r;
        int mi;
        r = '0;
        mi = int'(a[6:4]) - 1;
        if (a[7])
        begin
            if (a[6])
                r[15:0] = s.cnt_mem[a[5:2]];
            else
                r[9:0] = s.cap_mem[a[5:2]];
        end
        else if (a[6:4] == 3'h0)
        begin
            if (a[3:2] == 2'h0)
            begin
                r[CTL_START] = s.start;
                r[CTL_MODE] = s.mode;
                r[CTL_BUSY] = s.busy;
                r[CTL_OVF] = s.ovf_flag;
                r[CTL_SHARED] = s.shared;
                r[CTL_PRE +: 8] = s.preload;
            end
            else
                r[32] = 1'b1;
        end
        else if (mi < NMOD)
        begin
            unique case (a[3:2])
                MW_OSC: r[7:0] = s.osc_ctl[mi];
                MW_SKS: r[7:0] = s.sks[mi];
                MW_CAP: r[9:0] = s.ref_cap[mi];
                MW_CNT: r[31:0] = {s.ref_cnt[mi], s.sense_cnt[mi]};
            endcase
        end
        else
            r[32] = 1'b1;
        return r;
    endfunction

    // byte-lane merge of a write into the current value
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (st[i])
                r[8*i +: 8] = wd[8*i +: 8];
        end
        return r;
    endfunction

    // key in use per module: manual ignores slots 1..3
    always_comb
    begin
        for (int m = 0; m < NMOD; m++)
        begin
            if (q.mode)
                sel[m] = q.sks[m][1:0];
            else
                sel[m] = q.sks[m][{q.slot, 1'b0} +: 2];
        end
    end

    // edges of synchronised oscillators count once stages 2 and 3 agree
    assign rise_v = q.s2 & q.s3 & ~q.stab;
    assign st_rise = q.start & ~q.start_prev;
    assign st_fall = ~q.start & q.start_prev;

    // slot end: module 0 alone when shared, else all modules with keys
    always_comb
    begin
        logic all_done;
        all_done = 1'b1;
        for (int m = 0; m < NMOD; m++)
        begin
            if (|q.osc_ctl[m][3:0] && !q.mod_done[m])
                all_done = 1'b0;
        end
        slot_end = q.run && (q.shared ? q.mod_done[0] : all_done);
    end

    // all next-state logic
    always_comb
    begin
        logic [32:0] rd;
        logic [31:0] wm;
        logic [1:0] nk;
        logic tick;
        int mi;
        int ka;
        rd = '0;
        wm = '0;
        nk = 2'h0;
        tick = 1'b0;
        mi = 0;
        ka = 0;
        d = q;
        d.start_prev = q.start;
        d.irq = 1'b0;
        d.div = q.div + 2'h1;
        d.s1 = {ref_osc_i, key_osc_i};
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.stab = (q.s2 & q.s3) | (q.stab & (q.s2 ^ q.s3));

        // axi read channel: answer one cycle after the address is taken
        if (q.rvalid && s_axi_rready_i)
            d.rvalid = 1'b0;
        if (s_axi_arvalid_i && !q.rvalid)
        begin
            rd = reg_read(q, s_axi_araddr_i);
            d.rvalid = 1'b1;
            d.rdata = rd[31:0];
            d.rresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
        end

        // axi write channels taken in either order, applied once both held
        if (q.bvalid && s_axi_bready_i)
            d.bvalid = 1'b0;
        if (s_axi_awvalid_i && !q.aw_ok && !q.bvalid)
        begin
            d.aw_ok = 1'b1;
            d.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !q.w_ok && !q.bvalid)
        begin
            d.w_ok = 1'b1;
            d.wdata = s_axi_wdata_i;
            d.wstrb = s_axi_wstrb_i;
        end
        if (q.aw_ok && q.w_ok)
        begin
            rd = reg_read(q, q.awaddr);
            wm = wmerge(rd[31:0], q.wdata, q.wstrb);
            mi = int'(q.awaddr[6:4]) - 1;
            d.aw_ok = 1'b0;
            d.w_ok = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = rd[32] ? RESP_SLVERR : RESP_OKAY;
            if (q.awaddr[7])
            begin
                if (!q.awaddr[6])
                    d.cap_mem[q.awaddr[5:2]] = wm[9:0];
            end
            else if (q.awaddr[6:4] == 3'h0 && !rd[32])
            begin
                d.start = wm[CTL_START];
                d.mode = wm[CTL_MODE];
                d.shared = wm[CTL_SHARED];
                d.preload = wm[CTL_PRE +: 8];
                if (!wm[CTL_OVF])
                    d.ovf_flag = 1'b0; // writing 0 clears, hardware set below wins
            end
            else if (!rd[32])
            begin
                unique case (q.awaddr[3:2])
                    MW_OSC: d.osc_ctl[mi] = wm[7:0] & 8'hBF;
                    MW_SKS: d.sks[mi] = wm[7:0];
                    MW_CAP: d.ref_cap[mi] = wm[9:0];
                    MW_CNT: d.ref_cap[mi] = q.ref_cap[mi]; // counts are read only
                endcase
            end
        end

        // counters of each module while running and not yet overflowed
        for (int m = 0; m < NMOD; m++)
        begin
            ka = m * KPM + int'(sel[m]);
            tick = q.osc_ctl[m][OSC_TSS] ? (q.div == DIV_LAST) : rise_v[NKEY + m];
            if (q.run && q.start && !q.mod_done[m])
            begin
                if (rise_v[ka])
                    d.sense_cnt[m] = q.sense_cnt[m] + 16'h0001;
                if (rise_v[NKEY + m])
                    d.ref_cnt[m] = q.ref_cnt[m] + 16'h0001;
                if (tick)
                begin
                    d.unit_cnt[m] = q.unit_cnt[m] + 5'h01;
                    if (q.unit_cnt[m] == UNIT_MAX)
                    begin
                        if (q.slot_cnt[m] == SLOT_MAX)
                        begin
                            d.slot_cnt[m] = q.preload;
                            d.mod_done[m] = !q.shared || (m == 0);
                        end
                        else
                            d.slot_cnt[m] = q.slot_cnt[m] + 8'h01;
                    end
                end
            end
        end

        // scan sequencer
        unique case (q.state)
            ST_IDLE:
            begin
                if (st_rise)
                begin
                    d.busy = 1'b1;
                    d.mod_done = '0;
                    if (!q.mode)
                    begin
                        for (int m = 0; m < NMOD; m++)
                        begin
                            if (|q.osc_ctl[m][3:0])
                            begin
                                d.osc_ctl[m][OSC_KEY] = 1'b1;
                                d.osc_ctl[m][OSC_REF] = !q.osc_ctl[m][OSC_TSS];
                            end
                        end
                        d.slot = 2'h3;
                        d.first = 1'b1;
                        d.state = ST_LOAD;
                    end
                    else
                    begin
                        d.run = 1'b1;
                        d.state = ST_SCAN;
                    end
                end
            end
            ST_LOAD:
            begin
                // one 2N-byte move: next slot's capacitor value per module
                nk = q.slot + 2'h1;
                for (int m = 0; m < NMOD; m++)
                begin
                    ka = m * KPM + int'(q.sks[m][{nk, 1'b0} +: 2]);
                    d.ref_cap[m] = q.cap_mem[ka];
                end
                d.state = ST_STORE;
            end
            ST_STORE:
            begin
                // one 2N-byte move: this slot's count into its key location
                for (int m = 0; m < NMOD; m++)
                begin
                    ka = m * KPM + int'(q.sks[m][{q.slot, 1'b0} +: 2]);
                    d.cnt_mem[ka] = q.sense_cnt[m];
                end
                d.mod_done = '0;
                if (q.first)
                begin
                    d.first = 1'b0;
                    d.slot = 2'h0;
                    d.run = 1'b1;
                    d.state = ST_SCAN;
                end
                else if (q.slot == 2'h3)
                begin
                    d.busy = 1'b0;
                    d.ovf_flag = 1'b1;
                    d.irq = 1'b1;
                    d.state = ST_IDLE;
                end
                else
                begin
                    for (int m = 0; m < NMOD; m++)
                        d.sense_cnt[m] = 16'h0000;
                    d.slot = q.slot + 2'h1;
                    d.run = 1'b1;
                    d.state = ST_SCAN;
                end
            end
            ST_SCAN:
            begin
                if (slot_end)
                begin
                    d.run = 1'b0;
                    for (int m = 0; m < NMOD; m++)
                        d.unit_cnt[m] = 5'h00;
                    if (q.mode)
                    begin
                        d.busy = 1'b0;
                        d.ovf_flag = 1'b1;
                        d.irq = 1'b1;
                        d.state = ST_IDLE;
                    end
                    else
                        d.state = ST_LOAD;
                end
            end
        endcase

        // start cleared aborts the scan; slot counters are kept
        if (st_fall)
        begin
            for (int m = 0; m < NMOD; m++)
            begin
                d.sense_cnt[m] = 16'h0000;
                d.ref_cnt[m] = 16'h0000;
                d.unit_cnt[m] = 5'h00;
            end
            d.run = 1'b0;
            d.busy = 1'b0;
            d.state = ST_IDLE;
        end

        // busy falling switches every oscillator off, after any write
        if (q.busy && !d.busy)
        begin
            for (int m = 0; m < NMOD; m++)
            begin
                d.osc_ctl[m][OSC_REF] = 1'b0;
                d.osc_ctl[m][OSC_KEY] = 1'b0;
            end
        end
    end

    // single state register; reset only loads constants
    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            q <= '0;
            q.sks <= {NMOD{SKS_RST}};
        end
        else
            q <= d;
    end

    // outputs toward bus and analog side
    always_comb
    begin
        for (int m = 0; m < NMOD; m++)
        begin
            mod_o[m].ref_osc_en = q.osc_ctl[m][OSC_REF];
            mod_o[m].key_osc_en = q.osc_ctl[m][OSC_KEY];
            mod_o[m].key_pin_en = q.osc_ctl[m][3:0];
            mod_o[m].key_sel = sel[m];
            mod_o[m].ref_cap = q.ref_cap[m];
        end
    end
    assign s_axi_awready_o = !q.aw_ok && !q.bvalid;
    assign s_axi_wready_o = !q.w_ok && !q.bvalid;
    assign s_axi_bvalid_o = q.bvalid;
    assign s_axi_bresp_o = q.bresp;
    assign s_axi_arready_o = !q.rvalid;
    assign s_axi_rvalid_o = q.rvalid;
    assign s_axi_rdata_o = q.rdata;
    assign s_axi_rresp_o = q.rresp;
    assign touch_irq_o = q.irq;

    // checks of the sequencing
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);

    start_busy_a: assert property ((q.state == ST_IDLE) && st_rise |=> q.busy)
        else $error("busy not set after start rise");
    manual_sel_a: assert property ((q.mode && q.state == ST_SCAN)
        |-> mod_o[0].key_sel == q.sks[0][1:0])
        else $error("manual key select not from slot 0 field");
    auto_sel_a: assert property ((!q.mode && q.state == ST_SCAN && q.slot == 2'h2)
        |-> mod_o[0].key_sel == q.sks[0][5:4])
        else $error("auto slot 2 key select wrong");
    auto_seq_a: assert property ((q.state == ST_IDLE && st_rise && !q.mode)
        |=> q.state == ST_LOAD ##1 q.state == ST_STORE ##1 (q.state == ST_SCAN && q.slot == 2'h0))
        else $error("auto start sequence wrong");
    stop_clear_a: assert property ($fell(q.start) |=> (q.sense_cnt[0] == 16'h0000
        && q.unit_cnt[0] == 5'h00 && q.slot_cnt[0] == $past(q.slot_cnt[0])))
        else $error("start clear did not clear counts or lost slot counter");
    busy_fall_a: assert property ($fell(q.busy)
        |-> !q.osc_ctl[0][OSC_REF] && !q.osc_ctl[0][OSC_KEY])
        else $error("oscillators left on after busy fell");
    auto_osc_a: assert property ((q.state == ST_IDLE && st_rise && !q.mode
        && |q.osc_ctl[0][3:0]) |=> q.osc_ctl[0][OSC_KEY])
        else $error("auto start did not enable key oscillator");
    irq_flag_a: assert property (touch_irq_o |-> q.ovf_flag && !q.busy && q.state == ST_IDLE)
        else $error("interrupt without overflow flag and idle");
    ovf_halt_a: assert property ((q.mode && q.state == ST_SCAN && slot_end && q.start)
        |=> !q.run ##1 $stable(q.sense_cnt[0]))
        else $error("counters still running after overflow");
    clear_after_a: assert property ((q.state == ST_STORE && !q.first && q.slot != 2'h3)
        |=> q.sense_cnt[0] == 16'h0000)
        else $error("sense count not cleared after store");
    shared_end_a: assert property ((q.state == ST_SCAN && q.run && q.shared
        && q.mod_done[0]) |=> !q.run)
        else $error("shared slot counter overflow did not end slot");
    manual_done_c: cover property (q.mode && q.state == ST_SCAN ##1 touch_irq_o);
    auto_done_c: cover property (!q.mode && q.state == ST_STORE && q.slot == 2'h3 ##1 touch_irq_o);
    shared_c: cover property (q.shared && slot_end);
endmodule

/* verilog/tkscn_pkg.sv */
// shared constants, register map and types of the touch scan sequencer
// assumes one 25 MHz core clock and a 32-bit AXI4-Lite register slave
package tkscn_pkg;
    // structure: modules of four keys each
    localparam int NMOD = 4;
    localparam int KPM = 4;
    localparam int NKEY = NMOD * KPM;
    localparam int NSYN = NKEY + NMOD;

    // byte addresses of the register map
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] MOD_OFS = 8'h10;
    localparam logic [7:0] MOD_STRIDE = 8'h10;
    localparam logic [7:0] CAP_MEM_OFS = 8'h80;
    localparam logic [7:0] CNT_MEM_OFS = 8'hC0;
    // word index inside a module block
    localparam logic [1:0] MW_OSC = 2'h0;
    localparam logic [1:0] MW_SKS = 2'h1;
    localparam logic [1:0] MW_CAP = 2'h2;
    localparam logic [1:0] MW_CNT = 2'h3;

    // touch_control_zero field positions
    localparam int CTL_START = 0;
    localparam int CTL_MODE = 1;
    localparam int CTL_BUSY = 2;
    localparam int CTL_OVF = 3;
    localparam int CTL_SHARED = 4;
    localparam int CTL_PRE = 8;
    // module_osc_control field positions
    localparam int OSC_TSS = 7;
    localparam int OSC_REF = 5;
    localparam int OSC_KEY = 4;

    // values after reset and counter limits
    localparam logic [7:0] SKS_RST = 8'hE4;
    localparam logic [4:0] UNIT_MAX = 5'h1F;
    localparam logic [7:0] SLOT_MAX = 8'hFF;
    localparam logic [1:0] DIV_LAST = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // sequencer states, gray along idle-load-store-scan
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LOAD = 2'h1,
        ST_STORE = 2'h3,
        ST_SCAN = 2'h2
    } tkscn_fsm_type;

    // per-module controls toward the analog side
    typedef struct packed {
        logic ref_osc_en;
        logic key_osc_en;
        logic [3:0] key_pin_en;
        logic [1:0] key_sel;
        logic [9:0] ref_cap;
    } tkscn_mod_type;

    // whole state of the sequencer
    typedef struct packed {
        logic start;
        logic start_prev;
        logic mode;
        logic busy;
        logic ovf_flag;
        logic shared;
        logic [7:0] preload;
        logic [NMOD-1:0][7:0] osc_ctl;
        logic [NMOD-1:0][7:0] sks;
        logic [NMOD-1:0][9:0] ref_cap;
        logic [NMOD-1:0][15:0] sense_cnt;
        logic [NMOD-1:0][15:0] ref_cnt;
        logic [NMOD-1:0][4:0] unit_cnt;
        logic [NMOD-1:0][7:0] slot_cnt;
        logic [NMOD-1:0] mod_done;
        logic run;
        logic first;
        logic [1:0] slot;
        tkscn_fsm_type state;
        logic [1:0] div;
        logic irq;
        logic [NKEY-1:0][9:0] cap_mem;
        logic [NKEY-1:0][15:0] cnt_mem;
        logic [NSYN-1:0] s1;
        logic [NSYN-1:0] s2;
        logic [NSYN-1:0] s3;
        logic [NSYN-1:0] stab;
        logic aw_ok;
        logic w_ok;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tkscn_state_type;
endpackage
